// [stc_pkg.sv]
/*
 Shared constants for the upper timer control block: register offsets,
 field positions, reset values and prescale encodings.
 Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
*/
package stc_pkg;
    // Register byte offsets
    localparam logic [3:0] OFS_CONTROL = 4'h0;
    localparam logic [3:0] OFS_COUNT = 4'h4;
    localparam logic [3:0] OFS_PAIRED = 4'h8;
    // Upper timer control field positions
    localparam int BIT_RUN = 15;
    localparam int BIT_SIDL = 13;
    localparam int BIT_GATE = 6;
    localparam int BIT_PS_HI = 5;
    localparam int BIT_PS_LO = 4;
    localparam int BIT_CS = 1;
    // Paired control: 32-bit pair enable position
    localparam int BIT_PAIR32 = 3;
    // Writable bits of the control registers
    localparam logic [15:0] CTRL_MASK = 16'ha072;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    // Prescale encodings
    localparam logic [1:0] PS_DIV1 = 2'h0;
    localparam logic [1:0] PS_DIV8 = 2'h1;
    localparam logic [1:0] PS_DIV64 = 2'h2;
    localparam logic [1:0] PS_DIV256 = 2'h3;
    localparam logic [7:0] PS_MAX8 = 8'h07;
    localparam logic [7:0] PS_MAX64 = 8'h3f;
    localparam logic [7:0] PS_MAX256 = 8'hff;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : stc_pkg

// [stc_prescaler.sv]
/*
 Prescaler for the upper timer: divides qualified input ticks by 1, 8,
 64 or 256 and emits one tick pulse per full division.
 Assumes ticks arrive as single-cycle pulses on the same clock.
*/
`timescale 1ns/100ps
module stc_prescaler
    import stc_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Control
    input wire logic [1:0] prescale_select,
    input wire logic clr,
    // Ticks
    input wire logic tick_in,
    output logic tick_out
);
    logic [7:0] div_ff;
    logic [7:0] lim;

    // Terminal count for the selected ratio
    always_comb begin
        unique case (prescale_select)
            PS_DIV1: lim = 8'h00;
            PS_DIV8: lim = PS_MAX8;
            PS_DIV64: lim = PS_MAX64;
            PS_DIV256: lim = PS_MAX256;
        endcase
    end

    // Division counter; cleared when the timer stops so a restart is aligned
    always_ff @(posedge aclk) begin
        if (!aresetn || clr) begin
            div_ff <= 8'h00;
            tick_out <= 1'b0;
        end else begin
            tick_out <= 1'b0;
            if (tick_in) begin
                if (div_ff >= lim) begin
                    div_ff <= 8'h00;
                    tick_out <= 1'b1;
                end else begin
                    div_ff <= div_ff + 8'h01;
                end
            end
        end
    end
endmodule : stc_prescaler

// [stc_timer.sv]
/*
 Upper half timer with its control register, reached over AXI4-Lite.
 Counts the peripheral clock, gated when enabled, or rising edges of
 the external pin, with prescale and stop-in-idle; yields to the paired timer
 when that one runs in 32-bit mode.
 Assumes external pins are already synchronous to aclk.
*/
`timescale 1ns/100ps
module stc_timer
    import stc_pkg::*;
#(
    parameter int CNT_W = 16
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Timer pins and device state
    input wire logic external_count_pin,
    input wire logic gate_in,
    input wire logic idle_mode,
    // Count output
    output logic [CNT_W-1:0] count_out
);
    logic [15:0] ctrl_ff;
    logic [15:0] pair_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic pin_ff;
    logic aw_hold_ff;
    logic w_hold_ff;
    logic [3:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic [15:0] eff;
    logic run_enable;
    logic stop_in_idle;
    logic gate_accumulate_enable;
    logic clock_source_select;
    logic [1:0] prescale_select;
    logic pin_rise;
    logic raw_tick;
    logic ps_tick;
    logic active;
    logic wr_go;
    logic [15:0] nxt_wr;

    // Merge a 16-bit register with the low two byte lanes of a write
    function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [31:0] d,
                                               input logic [3:0] s);
        logic [15:0] r;
        r = old;
        if (s[0]) r[7:0] = d[7:0];
        if (s[1]) r[15:8] = d[15:8];
        return r;
    endfunction : lane_merge

    // In 32-bit mode the paired control register drives everything
    assign eff = pair_ff[BIT_PAIR32] ? pair_ff : ctrl_ff;
    assign run_enable = eff[BIT_RUN];
    assign stop_in_idle = eff[BIT_SIDL];
    assign gate_accumulate_enable = eff[BIT_GATE];
    assign clock_source_select = eff[BIT_CS];
    assign prescale_select = eff[BIT_PS_HI:BIT_PS_LO];

    // Source selection, gating and idle qualification
    assign pin_rise = external_count_pin & ~pin_ff;
    assign active = run_enable && !(stop_in_idle && idle_mode);
    always_comb begin
        if (clock_source_select) begin
            raw_tick = pin_rise;
        end else begin
            raw_tick = gate_accumulate_enable ? gate_in : 1'b1;
        end
        raw_tick = raw_tick && active;
    end

    stc_prescaler u_ps (
        .aclk(aclk),
        .aresetn(aresetn),
        .prescale_select(prescale_select),
        .clr(!run_enable),
        .tick_in(raw_tick),
        .tick_out(ps_tick)
    );

    // Pin edge history
    always_ff @(posedge aclk) begin
        if (!aresetn) pin_ff <= 1'b0;
        else pin_ff <= external_count_pin;
    end

    // Write channel capture; address and data accepted in either order
    assign wr_go = aw_hold_ff && w_hold_ff && !s_axi_bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_ff <= 1'b0;
            w_hold_ff <= 1'b0;
            awaddr_ff <= 4'h0;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_hold_ff && !s_axi_awready && !wr_go;
            s_axi_wready <= !w_hold_ff && !s_axi_wready && !wr_go;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_hold_ff <= 1'b0;
                w_hold_ff <= 1'b0;
            end
        end
    end

    // Write response; unmapped offsets get SLVERR
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awaddr_ff == OFS_CONTROL || awaddr_ff == OFS_COUNT || awaddr_ff == OFS_PAIRED)
                           ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Control registers; unimplemented bits stay zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff <= CTRL_RESET;
            pair_ff <= CTRL_RESET;
        end else if (wr_go) begin
            if (awaddr_ff == OFS_CONTROL) ctrl_ff <= lane_merge(ctrl_ff, wdata_ff, wstrb_ff) & CTRL_MASK;
            if (awaddr_ff == OFS_PAIRED)
                pair_ff <= lane_merge(pair_ff, wdata_ff, wstrb_ff) & (CTRL_MASK | (16'h0001 << BIT_PAIR32));
        end
    end

    // Count register; a software write overrides a tick in the same cycle
    assign nxt_wr = lane_merge(16'(cnt_ff), wdata_ff, wstrb_ff);
    always_ff @(posedge aclk) begin
        if (!aresetn) cnt_ff <= '0;
        else if (wr_go && awaddr_ff == OFS_COUNT) cnt_ff <= nxt_wr[CNT_W-1:0];
        else if (ps_tick) cnt_ff <= cnt_ff + 1'b1;
    end

    // Count output from a flop
    always_ff @(posedge aclk) begin
        if (!aresetn) count_out <= '0;
        else count_out <= cnt_ff;
    end

    // Read channel, one read at a time
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= RESP_OKAY;
                unique case (s_axi_araddr)
                    OFS_CONTROL: s_axi_rdata <= {16'h0000, ctrl_ff};
                    OFS_COUNT: s_axi_rdata <= 32'(cnt_ff);
                    OFS_PAIRED: s_axi_rdata <= {16'h0000, pair_ff};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule : stc_timer

// [stc_timer_monitor.sv]
/*
 Checker for the upper timer: count behaviour and read answer.
 Bound to stc_timer; sees its ports only.
*/
`timescale 1ns/100ps
module stc_timer_monitor
    import stc_pkg::*;
#(
    parameter int CNT_W = 16
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    // Timer
    input wire logic external_count_pin,
    input wire logic gate_in,
    input wire logic idle_mode,
    input wire logic [CNT_W-1:0] count_out
);
    logic [3:0] a_ff;
    logic [15:0] d_ff, c_ff, p_ff, e;
    logic bv_ff;
    // Shadow registers lag the block by a cycle; windows below absorb it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            a_ff <= '0;
            d_ff <= '0;
            c_ff <= '0;
            p_ff <= '0;
            bv_ff <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) a_ff <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready) d_ff <= s_axi_wdata[15:0];
            bv_ff <= s_axi_bvalid;
            if (s_axi_bvalid && !bv_ff && a_ff == OFS_CONTROL) c_ff <= d_ff & CTRL_MASK;
            if (s_axi_bvalid && !bv_ff && a_ff == OFS_PAIRED) p_ff <= d_ff & (CTRL_MASK | (16'h0001 << BIT_PAIR32));
        end
    end
    // Pair mode takes every control bit from the paired register
    assign e = p_ff[BIT_PAIR32] ? p_ff : c_ff;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Quiet stretch: condition holds and no write lands
    sequence s_calm(c);
        (c && !s_axi_bvalid)[*6];
    endsequence
    property p_run_hold; s_calm(!e[BIT_RUN]) |=> $stable(count_out); endproperty
    property p_idle_hold; s_calm(e[BIT_RUN] && e[BIT_SIDL] && idle_mode) |=> $stable(count_out); endproperty
    property p_gate_hold; s_calm(e[BIT_RUN] && !e[BIT_CS] && e[BIT_GATE] && !gate_in) |=> $stable(count_out); endproperty
    property p_ext_hold; s_calm(e[BIT_RUN] && e[BIT_CS] && !external_count_pin) |=> $stable(count_out); endproperty
    property p_pair_hold; s_calm(p_ff[BIT_PAIR32] && !p_ff[BIT_RUN]) |=> $stable(count_out); endproperty
    property p_step; (!s_axi_bvalid)[*4] |=> CNT_W'(count_out - $past(count_out)) <= 1; endproperty
    property p_advance;
        s_calm(e[BIT_RUN] && !e[BIT_CS] && e[5:4] == PS_DIV1 && (!e[BIT_GATE] || gate_in) && !(e[BIT_SIDL] && idle_mode))
            |=> count_out != $past(count_out);
    endproperty
    property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_run_hold: assert property (p_run_hold) else $error("count moved while stopped");
    a_idle_hold: assert property (p_idle_hold) else $error("count moved in idle");
    a_gate_hold: assert property (p_gate_hold) else $error("count moved with gate closed");
    a_ext_hold: assert property (p_ext_hold) else $error("count moved with pin low");
    a_pair_hold: assert property (p_pair_hold) else $error("upper control ran in pair mode");
    a_step: assert property (p_step) else $error("count jumped");
    a_advance: assert property (p_advance) else $error("count stalled");
    a_rd: assert property (p_rd) else $error("late read answer");
endmodule : stc_timer_monitor

// [stc_timer_bench.sv]
/*
 Testbench for the upper timer, driving its bus and pins directly.
 Assumes stc_pkg and the monitor are compiled first.
*/
`timescale 1ns/100ps
module stc_timer_bench
    import stc_pkg::*;
;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, external_count_pin = 0, gate_in = 0, idle_mode = 0, tog = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [3:0] s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, val;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [15:0] count_out;
    int fail_count = 0, tests_run = 0;
    int dv[4] = '{1, 8, 64, 256};
    stc_timer i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .external_count_pin(external_count_pin), .gate_in(gate_in), .idle_mode(idle_mode), .count_out(count_out));
    initial forever #2 aclk = ~aclk;
    // Pin rises every second cycle while enabled
    always @(posedge aclk) external_count_pin <= tog ? !external_count_pin : 1'b0;
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        val = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rng(input logic [31:0] lo, input logic [31:0] hi);
        tests_run++;
        if ((val >= lo && val <= hi) !== 1'b1) begin
            fail_count++;
            $display("Error at %0t: count %h outside %0d..%0d", $time, val, lo, hi);
        end
    endtask : rng
    // Window slack covers the bus cycles around start and stop
    task automatic run(input logic [15:0] c, input logic [15:0] p, input int n, input int lo, input int hi);
        wr(OFS_COUNT, '0);
        wr(OFS_PAIRED, {16'h0, p});
        wr(OFS_CONTROL, {16'h0, c});
        repeat (n) @(posedge aclk);
        wr(OFS_CONTROL, '0);
        wr(OFS_PAIRED, '0);
        rd(OFS_COUNT);
        rng(lo, hi);
        // The count output must fall in the same lo..hi window as the register once stopped
        val = {16'h0, count_out};
        rng(lo, hi);
    endtask : run
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : summarize
    initial begin
        repeat (30000) @(posedge aclk);
        fail_count++;
        summarize();
    end
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rd(OFS_CONTROL);
        chk(val, 32'h0);
        wr(OFS_CONTROL, 32'hffff_ffff);
        chk({30'h0, resp}, {30'h0, RESP_OKAY});
        rd(OFS_CONTROL);
        chk(val, {16'h0, CTRL_MASK});
        // Byte lanes: only the low lane of the count is rewritten
        wr(OFS_COUNT, 32'h0000_ffff);
        s_axi_wstrb <= 4'h1;
        wr(OFS_COUNT, 32'h0);
        s_axi_wstrb <= 4'hf;
        rd(OFS_COUNT);
        chk(val, 32'h0000_ff00);
        wr(4'hc, 32'h1);
        chk({30'h0, resp}, {30'h0, RESP_SLVERR});
        rd(4'hc);
        chk(val, 32'h0);
        chk({30'h0, resp}, {30'h0, RESP_SLVERR});
        idle_mode <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            run(16'h8000 | 16'(i << BIT_PS_LO), 16'h0, 16 * dv[i], 16, 24);
        end
        run(16'ha000, 16'h0, 64, 0, 0);
        idle_mode <= 1'b0;
        run(16'h8040, 16'h0, 64, 0, 0);
        gate_in <= 1'b1;
        run(16'h8040, 16'h0, 16, 16, 24);
        gate_in <= 1'b0;
        run(16'h8002, 16'h0, 64, 0, 0);
        tog <= 1'b1;
        run(16'h8042, 16'h0, 32, 16, 22);
        tog <= 1'b0;
        run(16'h8000, 16'h0008, 64, 0, 0);
        run(16'h0000, 16'h8008, 16, 16, 32);
        // Pair in idle: the paired stop-in-idle bit alone decides
        idle_mode <= 1'b1;
        run(16'h0000, 16'ha008, 16, 0, 0);
        run(16'h2000, 16'h8008, 16, 16, 32);
        idle_mode <= 1'b0;
        summarize();
    end
endmodule : stc_timer_bench
bind stc_timer stc_timer_monitor #(.CNT_W(CNT_W)) i_mon (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .external_count_pin(external_count_pin), .gate_in(gate_in),
    .idle_mode(idle_mode), .count_out(count_out));
